// >>> core/acc_pkg.sv
package acc_pkg;
    // control byte layout: start, reserved, pin select, channel select
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_PIN_LSB   = 3;
    localparam int CTRL_CH_LSB    = 0;
    localparam int SEL_W          = 3;
    localparam int CODE_W         = 12;
    localparam logic [11:0] CODE_FULL_SCALE = 12'h0FFF;
    localparam logic [11:0] CODE_MSB_TRIAL  = 12'h0800;
    localparam logic [11:0] CODE_RESET      = 12'h0000;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [7:0]  CTRL_AN0_FOUR_PINS = 8'h20;
    localparam logic [7:0]  MASK_FOUR_PINS     = 8'h0F;
    // conversion sequencing, counted in conversion clock ticks
    localparam int CONV_TICKS   = 16;
    localparam int SAMPLE_TICKS = 2;
    localparam logic [3:0] TICK_TRIAL  = 4'h2;
    localparam logic [3:0] TICK_LAST   = 4'hF;
    // system clocks per conversion clock per step of the select field
    localparam int DIV_UNIT = 4;
    localparam logic [5:0] DIV_RESET = 6'h00;

    // shared port A pins 1..3, index 0 is pin 1
    typedef struct packed {
        logic [2:0] data;
        logic [2:0] drive_en;
        logic [2:0] pullup_en;
    } acc_pa_t;
    localparam acc_pa_t PA_RESET = '0;
endpackage : acc_pkg

// >>> core/acc_clkdiv.sv
`timescale 1ns/1ps
module acc_clkdiv (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // control
    input  wire logic       restart,
    input  wire logic [2:0] sel,
    // one-cycle conversion clock enable
    output logic            tick
);
    logic [5:0] cnt;
    // divide by (sel+1) units, so the slowest select gives eight times the fastest
    wire  [5:0] div_last = 6'((32'(sel) + 1) * acc_pkg::DIV_UNIT - 1);
    wire        wrap     = (cnt >= div_last);

    // restart realigns the phase to the start of a conversion
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt  <= acc_pkg::DIV_RESET;
            tick <= 1'b0;
        end else begin
            cnt  <= (restart || wrap) ? acc_pkg::DIV_RESET : cnt + 6'h01;
            tick <= wrap && !restart;
        end
    end
endmodule : acc_clkdiv

// >>> core/acc_top.sv
`timescale 1ns/1ps
// Functional notes
// - pin select zero, whatever the channel select, means no pin on the converter, plain I/O, analog powered down.
// - completion shows both on the pending flag and on the interrupt request pulse.
// - the pending flag is high while a conversion is outstanding and low once the result is ready.
// - a conversion takes sixteen conversion clock periods from start to completion.
// - the result is a 12-bit code with full scale FFF, one step being the reference over 4096.
// - a half-step offset moves code transitions half a step early.
// - the result is readable as a low byte and a high byte after completion.
// - control value 00100000B makes four port B pins analog and connects analog input zero.
// - comparator enable low leaves all three shared port A pins as normal I/O.
// - comparator enable high routes pins 1 and 2 to the inputs, and pin 3 to the output only with comparator output enable also high.
// - while enabled the port bits of pins 1 and 2 do nothing but pin 3 stays readable.
// - comparator output enable drops the pull-ups and the normal driver of the output pin.
// - with comparator output enable, reading pin 3 returns the comparator output.
module acc_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // converter control from software
    input  wire logic [7:0]  adc_control_reg,
    input  wire logic [2:0]  adc_clock_select_reg,
    // analog side of the converter
    input  wire logic        sar_cmp_in,
    output logic [11:0]      sar_trial_code,
    output logic             sample_hold,
    output logic             half_lsb_offset_en,
    output logic             adc_powered,
    output logic [2:0]       adc_mux_channel,
    output logic [7:0]       port_b_analog_mask,
    input  wire logic [7:0]  port_b_pullup_cfg,
    output logic [7:0]       port_b_pullup_en,
    // converter status and result
    output logic             conversion_pending_flag,
    output logic             adc_irq,
    output logic [7:0]       result_low,
    output logic [7:0]       result_high,
    // comparator control and analog output
    input  wire logic        comparator_enable,
    input  wire logic        comparator_output_pin_enable,
    input  wire logic        comparator_raw,
    output logic             comparator_powered,
    // shared port A pins 1..3
    input  acc_pkg::acc_pa_t port_a_cfg,
    input  wire logic [2:0]  port_a_pin_in,
    output acc_pkg::acc_pa_t port_a_pins,
    output logic [2:0]       port_a_read
);
    // field decode
    wire [2:0] pin_sel = adc_control_reg[acc_pkg::CTRL_PIN_LSB +: acc_pkg::SEL_W];
    wire [2:0] ch_sel  = adc_control_reg[acc_pkg::CTRL_CH_LSB +: acc_pkg::SEL_W];
    wire       start   = adc_control_reg[acc_pkg::CTRL_START_BIT];
    wire       powered = (pin_sel != 3'h0);

    // two-flop synchronisers for analog comparator and pin inputs
    logic [4:0] sync1;
    logic [4:0] sync2;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= {sar_cmp_in, comparator_raw, port_a_pin_in};
            sync2 <= sync1;
        end
    end
    wire       sar_cmp_s = sync2[4];
    wire       cmp_s     = sync2[3];
    wire [2:0] pin_s     = sync2[2:0];

    // start edge tracking; software drives start on this clock
    logic start_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) start_q <= 1'b0;
        else        start_q <= start;
    end
    wire start_fall = start_q && !start && powered;

    logic tick;
    acc_clkdiv u_div (
        .clk     (clk),
        .rst_b   (rst_b),
        .restart (start || start_fall),
        .sel     (adc_clock_select_reg),
        .tick    (tick)
    );

    // successive approximation sequencer
    logic        busy;
    logic [3:0]  step;
    logic [11:0] trial;
    wire         step_tick = busy && tick;
    wire         done      = step_tick && (step == acc_pkg::TICK_LAST);
    wire [3:0]   res_bit   = 4'(14 - 32'(step));
    wire [3:0]   set_bit   = 4'(13 - 32'(step));
    wire         resolving = (step > acc_pkg::TICK_TRIAL) && (step < acc_pkg::TICK_LAST);
    // a bit stays set only when the input sits above the trial level
    wire [11:0]  kept      = sar_cmp_s ? trial : (trial & ~(12'h0001 << res_bit));
    wire [11:0]  next_trial =
        (step == acc_pkg::TICK_TRIAL) ? acc_pkg::CODE_MSB_TRIAL :
        (resolving && step <= 4'hD)   ? (kept | (12'h0001 << set_bit)) :
        resolving                     ? kept : trial;

    // start high resets; fall launches; the last tick ends the conversion
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy  <= 1'b0;
            step  <= 4'h0;
            trial <= acc_pkg::CODE_RESET;
        end else if (start || !powered) begin
            busy  <= 1'b0;
            step  <= 4'h0;
            trial <= acc_pkg::CODE_RESET;
        end else if (start_fall) begin
            busy  <= 1'b1;
            step  <= 4'h0;
        end else if (step_tick) begin
            busy  <= !done;
            step  <= step + 4'h1;
            trial <= next_trial;
        end
    end

    // pin mask: low pin_sel pins become analog, the rest stay port pins
    wire  [7:0] next_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_mask
            assign next_mask[gi] = (gi < 32'(pin_sel));
        end
    endgenerate

    // comparator pin sharing
    wire cmp_on  = comparator_enable;
    wire cmp_out = comparator_enable && comparator_output_pin_enable;
    acc_pkg::acc_pa_t next_pa;
    assign next_pa.data      = {cmp_out ? cmp_s : port_a_cfg.data[2], port_a_cfg.data[1:0]};
    assign next_pa.drive_en  = {cmp_out | port_a_cfg.drive_en[2],
                                cmp_on ? 2'b00 : port_a_cfg.drive_en[1:0]};
    assign next_pa.pullup_en = cmp_out ? 3'b000 :
                               {port_a_cfg.pullup_en[2],
                                cmp_on ? 2'b00 : port_a_cfg.pullup_en[1:0]};
    wire [2:0] next_read = {cmp_out ? cmp_s : pin_s[2],
                            cmp_on ? 2'b00 : pin_s[1:0]};

    // pending: set by a start, cleared at completion, holds its value otherwise
    wire next_pending = start ? 1'b1 : (done ? 1'b0 : conversion_pending_flag);

    // every output comes from a flip-flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conversion_pending_flag <= 1'b0;
            adc_irq            <= 1'b0;
            result_low         <= acc_pkg::BYTE_RESET;
            result_high        <= acc_pkg::BYTE_RESET;
            sar_trial_code     <= acc_pkg::CODE_RESET;
            sample_hold        <= 1'b0;
            half_lsb_offset_en <= 1'b0;
            adc_powered        <= 1'b0;
            adc_mux_channel    <= 3'h0;
            port_b_analog_mask <= 8'h00;
            port_b_pullup_en   <= 8'h00;
            comparator_powered <= 1'b0;
            port_a_pins        <= acc_pkg::PA_RESET;
            port_a_read        <= 3'h0;
        end else begin
            conversion_pending_flag <= next_pending;
            adc_irq            <= done;
            if (done) begin
                result_low  <= kept[7:0];
                result_high <= {4'h0, kept[11:8]};
            end
            sar_trial_code     <= trial; // settled code only, the decision must not feed back
            sample_hold        <= busy && (step < 4'(acc_pkg::SAMPLE_TICKS));
            half_lsb_offset_en <= powered;
            adc_powered        <= powered;
            adc_mux_channel    <= powered ? ch_sel : 3'h0;
            port_b_analog_mask <= next_mask;
            port_b_pullup_en   <= port_b_pullup_cfg & ~next_mask;
            comparator_powered <= cmp_on;
            port_a_pins        <= next_pa;
            port_a_read        <= next_read;
        end
    end

    // ---- checks ----
    logic [4:0] ticks_seen;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)          ticks_seen <= 5'h00;
        else if (start_fall) ticks_seen <= 5'h00;
        else if (step_tick)  ticks_seen <= ticks_seen + 5'h01;
    end

    property p_power_down;
        @(posedge clk) disable iff (!rst_b)
        (pin_sel == 3'h0) |=> (!adc_powered && port_b_analog_mask == 8'h00);
    endproperty
    a_power_down: assert property (p_power_down) else $error("converter not idle");

    property p_start_reset;
        @(posedge clk) disable iff (!rst_b)
        start |=> (conversion_pending_flag && !busy);
    endproperty
    a_start_reset: assert property (p_start_reset) else $error("start did not reset");

    property p_fall_begins;
        @(posedge clk) disable iff (!rst_b)
        start_fall |=> busy;
    endproperty
    a_fall_begins: assert property (p_fall_begins) else $error("conversion not begun");

    property p_done_signals;
        @(posedge clk) disable iff (!rst_b)
        done |=> (adc_irq && !conversion_pending_flag) ##1 !adc_irq;
    endproperty
    a_done_signals: assert property (p_done_signals) else $error("bad completion");

    property p_pending_holds;
        @(posedge clk) disable iff (!rst_b)
        (busy && !start) |=> conversion_pending_flag || $past(done);
    endproperty
    a_pending_holds: assert property (p_pending_holds) else $error("pending dropped");

    property p_sixteen;
        @(posedge clk) disable iff (!rst_b)
        done |-> (ticks_seen == 5'(acc_pkg::CONV_TICKS - 1));
    endproperty
    a_sixteen: assert property (p_sixteen) else $error("wrong tick count");

    property p_result;
        @(posedge clk) disable iff (!rst_b)
        done |=> ({result_high[3:0], result_low} == $past(kept)) && result_high[7:4] == 4'h0;
    endproperty
    a_result: assert property (p_result) else $error("result mismatch");

    property p_an0_four;
        @(posedge clk) disable iff (!rst_b)
        (adc_control_reg == acc_pkg::CTRL_AN0_FOUR_PINS) |=>
            (port_b_analog_mask == acc_pkg::MASK_FOUR_PINS && adc_mux_channel == 3'h0);
    endproperty
    a_an0_four: assert property (p_an0_four) else $error("AN0 setup wrong");

    property p_cmp_off;
        @(posedge clk) disable iff (!rst_b)
        !comparator_enable |=> (port_a_pins == $past(port_a_cfg));
    endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("pins not plain I/O");

    property p_cmp_out;
        @(posedge clk) disable iff (!rst_b)
        (comparator_enable && comparator_output_pin_enable) |=>
            (port_a_pins.drive_en == 3'b100 && port_a_pins.pullup_en == 3'b000
             && port_a_read[2] == $past(cmp_s) && port_a_read[1:0] == 2'b00);
    endproperty
    a_cmp_out: assert property (p_cmp_out) else $error("comparator routing wrong");

    c_conversion: cover property (@(posedge clk) disable iff (!rst_b) done);
    c_an0:        cover property (@(posedge clk) disable iff (!rst_b)
                                  start_fall && ch_sel == 3'h0);
    c_cmp_out:    cover property (@(posedge clk) disable iff (!rst_b) cmp_out && cmp_s);
    c_full_scale: cover property (@(posedge clk) disable iff (!rst_b)
                                  done && kept == acc_pkg::CODE_FULL_SCALE);
endmodule : acc_top

// >>> tb/acc_sar_model.sv
`timescale 1ns/1ps
// analog input source and trial comparator of the converter
module acc_sar_model (
    // clock
    input  wire logic        clk,
    // converter side
    input  wire logic [11:0] sar_trial_code,
    input  wire logic        sample_hold,
    input  wire logic        half_lsb_offset_en,
    input  wire logic        adc_powered,
    // input level in quarter steps
    input  wire logic [13:0] vin4,
    // decision back to the converter
    output logic             sar_cmp_in
);
    logic [14:0] held;
    logic        junk;
    logic [14:0] level;
    // track while sampling, then hold; unpowered decisions are junk that toggles
    always @(posedge clk) begin
        if (sample_hold) begin
            held <= {1'b0, vin4};
        end
        junk <= ~junk;
    end
    initial held = '0;
    initial junk = 1'b0;
    assign level = held + (half_lsb_offset_en ? 15'h0002 : 15'h0000);
    assign sar_cmp_in = adc_powered ? (level > {1'b0, sar_trial_code, 2'b00}) : junk;
endmodule : acc_sar_model

// >>> tb/acc_top_tb_top.sv
`timescale 1ns/1ps
module acc_top_tb_top;
    logic clk = 0, rst_b = 0, sar_cmp_in, comparator_enable = 0, cmp_oe = 0, raw = 0;
    logic [7:0] ctrl = '0, pull_cfg = '0, mask, pull_en, res_lo, res_hi;
    logic [2:0] csel = '0, mux, pa_in = '0, pa_read;
    logic [11:0] trial;
    logic [13:0] vin4 = '0;
    logic sh, half, powered, pending, irq, cmp_pw;
    acc_pkg::acc_pa_t pa_cfg = '0, pa_pins, ex;
    int fails = 0, total_checks = 0, cycles = 0;
    logic [31:0] seed = 32'd95684;
    acc_top DUT (.clk(clk), .rst_b(rst_b), .adc_control_reg(ctrl), .adc_clock_select_reg(csel),
        .sar_cmp_in(sar_cmp_in), .sar_trial_code(trial), .sample_hold(sh),
        .half_lsb_offset_en(half), .adc_powered(powered), .adc_mux_channel(mux),
        .port_b_analog_mask(mask), .port_b_pullup_cfg(pull_cfg), .port_b_pullup_en(pull_en),
        .conversion_pending_flag(pending), .adc_irq(irq), .result_low(res_lo),
        .result_high(res_hi), .comparator_enable(comparator_enable),
        .comparator_output_pin_enable(cmp_oe), .comparator_raw(raw),
        .comparator_powered(cmp_pw), .port_a_cfg(pa_cfg), .port_a_pin_in(pa_in),
        .port_a_pins(pa_pins), .port_a_read(pa_read));
    acc_sar_model sar (.clk(clk), .sar_trial_code(trial), .sample_hold(sh),
        .half_lsb_offset_en(half), .adc_powered(powered), .vin4(vin4), .sar_cmp_in(sar_cmp_in));
    initial forever #5 clk = ~clk;
    // hang guard, ceiling well above the longest expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            complete_run();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // odd quarter-step levels never tie with a trial level
    function automatic logic [11:0] exp_code(input logic [13:0] v);
        logic [14:0] c;
        c = ({1'b0, v} + 15'h0001) >> 2;
        return (c > 15'h0FFF) ? acc_pkg::CODE_FULL_SCALE : c[11:0];
    endfunction : exp_code
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv, input string what);
        total_checks++;
        if (seen !== expv) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, expv, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // one start pulse, then wait for completion and check result and timing
    task automatic conv(input logic [2:0] s, input logic [2:0] pins, input logic [2:0] ch,
                        input logic [13:0] v);
        int n, p;
        p = (s + 1) * acc_pkg::DIV_UNIT;
        @(posedge clk);
        csel <= s;
        vin4 <= v;
        pull_cfg <= 8'(rnd());
        ctrl <= {1'b1, 1'b0, pins, ch};
        tick(1);
        chk(pending, 1, "pending at start");
        @(posedge clk);
        ctrl[7] <= 1'b0;
        tick(2);
        chk(mux, ch, "mux channel");
        chk(mask, 8'hFF >> (8 - pins), "analog mask");
        chk(pull_en, pull_cfg & ~(8'hFF >> (8 - pins)), "port b pullups");
        for (n = 2; n < 20 * p + 20 && irq !== 1'b1; n++) tick(1);
        chk(n >= 15 * p && n <= 16 * p + 4, 1, "conversion time");
        chk(pending, 0, "pending at done");
        chk({res_hi, res_lo}, {4'h0, exp_code(v)}, "result bytes");
        tick(1);
        chk(irq, 0, "irq one cycle");
    endtask : conv
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        tick(2);
        chk({pending, irq, res_hi, res_lo}, 0, "reset outputs");
        // converter off: start only raises pending, pins stay plain
        pull_cfg <= 8'hA5;
        ctrl <= 8'h87;
        tick(2);
        ctrl <= 8'h07;
        tick(200);
        chk({powered, half, mask, mux}, 0, "converter off");
        chk({pending, irq, pull_en}, 10'h2A5, "no conversion");
        $display("test off done");
        // fixed control byte, then corners and random conversions
        conv(3'h1, 3'h4, 3'h0, 14'h3FFF);
        chk({powered, mask}, {1'b1, acc_pkg::MASK_FOUR_PINS}, "four pins analog");
        conv(3'h0, 3'h1, 3'h0, 14'h0001);
        conv(3'h7, 3'h7, 3'h7, 14'h0003);
        conv(3'h2, 3'h2, 3'h5, 14'h3FFB);
        // restart in mid conversion: later input wins
        vin4 <= 14'h1235;
        ctrl <= 8'hA0;
        tick(2);
        ctrl <= 8'h20;
        tick(30);
        chk(irq, 0, "no early done");
        conv(3'h3, 3'h4, 3'h0, 14'h0ABD);
        repeat (8) conv(3'(rnd()), 3'(rnd() % 7 + 1), 3'(rnd()), 14'(rnd() | 32'h0000_0001));
        // clearing the select needs no start and powers the converter down
        ctrl <= 8'h00;
        tick(3);
        chk({powered, mask, mux, pending, irq}, 0, "select cleared");
        $display("test converter done");
        // comparator pin sharing, every enable combination
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {comparator_enable, cmp_oe} <= i[1:0];
            pa_cfg <= acc_pkg::acc_pa_t'(9'(rnd()));
            pa_in <= 3'(rnd());
            raw <= 1'(rnd());
            tick(5);
            ex = pa_cfg;
            if (comparator_enable) begin
                ex.drive_en[1:0] = 2'b00;
                ex.pullup_en[1:0] = 2'b00;
            end
            if (comparator_enable && cmp_oe) begin
                ex.drive_en[2] = 1'b1;
                ex.data[2] = raw;
                ex.pullup_en = 3'b000;
            end
            chk(cmp_pw, comparator_enable, "comparator power");
            chk({pa_pins.drive_en, pa_pins.pullup_en}, {ex.drive_en, ex.pullup_en},
                "port a drive");
            chk(pa_pins.data[2], ex.data[2], "output pin data");
            if (!comparator_enable) chk(pa_pins, ex, "plain port a");
            chk(pa_read, comparator_enable ? {cmp_oe ? raw : pa_in[2], 2'b00} : pa_in,
                "port a read");
        end
        $display("test comparator done");
        complete_run();
    end
endmodule : acc_top_tb_top
